// ===== rtl/srst_pkg.sv
// Purpose: shared constants and types of the system reset controller
// Assumes: one system clock, register port with read data one cycle later
// Notes: byte offsets of the register port, field positions, reset values
package srst_pkg;
   // system clock
   localparam int CLK_PERIOD_NS = 50;

   // least time the internal reset stays low after every source has gone quiet
   localparam int RST_STRETCH_NS = 1000;
   localparam int RST_STRETCH_RAW = (RST_STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_STRETCH_CYC = (RST_STRETCH_RAW < 1) ? 1 : RST_STRETCH_RAW;
   localparam int CNT_W = 8;

   // register port
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] OFS_IDENT0 = 8'h00;
   localparam logic [7:0] OFS_IDENT1 = 8'h04;
   localparam logic [7:0] OFS_CAPABILITY = 8'h08;
   localparam logic [7:0] OFS_CAUSE = 8'h0C;
   localparam logic [7:0] OFS_SUPPLY_CTRL = 8'h10;
   localparam logic [7:0] OFS_PERIPH_RST = 8'h14;
   localparam logic [7:0] OFS_CORE_IRQ_RST = 8'h18;
   localparam logic [7:0] OFS_PIN_ALT = 8'h1C;
   localparam logic [7:0] OFS_WDT_CTRL = 8'h20;
   localparam logic [7:0] OFS_STATUS = 8'h24;

   // reset cause flag positions
   localparam int CAUSE_W = 5;
   localparam int CAUSE_EXT = 0;
   localparam int CAUSE_POR = 1;
   localparam int CAUSE_BOR = 2;
   localparam int CAUSE_WDT = 3;
   localparam int CAUSE_SW = 4;
   localparam logic [CAUSE_W-1:0] CAUSE_RESET = 5'h00;

   // control field positions
   localparam int BOR_EN_BIT = 1;
   localparam int SYS_REQ_BIT = 2;
   localparam int ALT_SEL_BIT = 0;
   localparam int WDT_EN_BIT = 0;

   // status field positions
   localparam int ST_RUN_BIT = 0;
   localparam int ST_POWERED_BIT = 1;
   localparam int ST_FIRST_TO_BIT = 2;
   localparam int ST_TMODE0_BIT = 3;
   localparam int ST_TMODE1_BIT = 4;

   // reset synchroniser width and value after reset: pin low and power-on shown active, brown-out not
   localparam int SRC_W = 3;
   localparam int SRC_POR = 0;
   localparam int SRC_EXT = 1;
   localparam int SRC_BOR = 2;
   localparam logic [SRC_W-1:0] SRC_INIT = 3'h3;

   // sequencer states
   typedef enum logic [2:0] {
      ST_HOLD,
      ST_STRETCH,
      ST_FETCH_SP,
      ST_FETCH_PC,
      ST_FETCH_INSN,
      ST_RUN
   } srst_state_t;
endpackage

// ===== rtl/srst_sync_if.sv
// Purpose: carries raw reset sources into the synchroniser and back
// Assumes: raw side is driven by the controller, synced side by the synchroniser
// Notes: width is a parameter
interface srst_sync_if #(parameter int W = 1);
   logic [W-1:0] raw;
   logic [W-1:0] synced;
   modport src (output raw, input synced);
   modport dst (input raw, output synced);
endinterface

// ===== rtl/srst_sync.sv
// Purpose: two flip-flop synchroniser for the reset source levels
// Assumes: synchronous active-low reset to a constant
// Notes: the first stage is read by the second stage only
module srst_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clock,
   input wire logic rstn,
   srst_sync_if.dst port
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } srst_sync_state_t;

   srst_sync_state_t state_reg;
   srst_sync_state_t state_next;

   // shift the raw level through two stages
   always_comb begin
      state_next = state_reg;
      state_next.meta = port.raw;
      state_next.stable = state_reg.meta;
   end

   // state register
   always_ff @(posedge clock) begin
      if (!rstn) begin
         state_reg.meta <= INIT;
         state_reg.stable <= INIT;
      end else begin
         state_reg <= state_next;
      end
   end

   assign port.synced = state_reg.stable;
endmodule // srst_sync

// ===== rtl/srst_ctrl.sv
// Purpose: system reset controller, gathers sources and sequences release
// Assumes: rstn is the controller's own power-up reset; sources asynchronous pins
// Notes: registers on a plain port, read data one cycle after the read strobe
//
// How it works
// - five sources each start a reset sequence
// - power-on resets core, peripherals and test port
// - pin reset spares tap, resets pin config
// - brown-out, software, watchdog spare test port
// - peripheral reset touches selected peripherals only
// - system request bit write starts system reset
// - the causing source sets its cause flag
// - cause flags are sticky across reset sequences
// - power-on or pin cause clears other flags
// - power-on holds reset until detector inactive
// - after release fetch stack, counter, instruction
// - power-on detector honoured on first power-up only
// - identification and capability registers are read-only
// - nmi pin is gpio until alternate select
// - brown-out resets only when enabled, holds
// - set-then-clear peripheral bit resets all clocks
// - second watchdog time-out before clear resets
module srst_ctrl #(
   parameter int NPERIPH = 8,
   parameter logic [31:0] IDENT0 = 32'h0000_1234, // arbitrary value
   parameter logic [31:0] IDENT1 = 32'h0000_5678, // arbitrary value
   parameter logic [31:0] CAPABILITY = 32'h0000_00FF // arbitrary value
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [srst_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [srst_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [srst_pkg::DATA_W-1:0] reg_rdata,
   input wire logic por_active,
   input wire logic ext_rst_n,
   input wire logic brownout_detect,
   input wire logic wdt_timeout,
   input wire logic wdt_irq_clear,
   input wire logic test_mode_pin0,
   input wire logic test_mode_pin1,
   output logic core_rst_n,
   output logic dbg_tap_rst_n,
   output logic dbg_pin_cfg_rst_n,
   output logic [NPERIPH-1:0] periph_rst_n,
   output logic boot_fetch_sp,
   output logic boot_fetch_pc,
   output logic boot_fetch_insn,
   output logic core_run,
   output logic nmi_select
);
   ////////////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      srst_pkg::srst_state_t st;
      logic [srst_pkg::CNT_W-1:0] cnt;
      logic [srst_pkg::CAUSE_W-1:0] reset_cause_flags;
      logic powered;
      logic por_dom;
      logic pin_dom;
      logic first_to;
      logic brownout_reset_enable;
      logic wdt_reset_enable;
      logic [NPERIPH-1:0] peripheral_reset_regs;
      logic alt_function_select;
      logic [srst_pkg::DATA_W-1:0] rdata;
   } srst_ctrl_state_t;

   srst_ctrl_state_t state_reg;
   srst_ctrl_state_t state_next;

   // gives clocks and memories time to settle
   // before the first fetch
   localparam logic [srst_pkg::CNT_W-1:0] STRETCH_LAST =
      srst_pkg::CNT_W'(srst_pkg::RST_STRETCH_CYC - 1);

   ////////////////////////////////////////////////////////////////////////////////
   // source synchronisers

   // rstn leaves power-on and pin shown active,
   // so the controller's own power-up counts
   // as a power-on reset and sets that flag
   srst_sync_if #(.W(srst_pkg::SRC_W)) src_if ();

   // level sources enter the clock domain through two flops
   // the pin is inverted so every raw bit is active high
   assign src_if.raw[srst_pkg::SRC_POR] = por_active;
   assign src_if.raw[srst_pkg::SRC_EXT] = ~ext_rst_n;
   assign src_if.raw[srst_pkg::SRC_BOR] = brownout_detect;

   srst_sync #(
      .W(srst_pkg::SRC_W),
      .INIT(srst_pkg::SRC_INIT)
   ) u_sync (
      .clock(clock),
      .rstn(rstn),
      .port(src_if)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // source qualification

   logic por_s;
   logic ext_s;
   logic bor_s;
   logic por_ev;
   logic ext_ev;
   logic bor_ev;
   logic wdt_ev;
   logic sw_ev;
   logic any_ev;
   logic level_busy;
   logic wr_hit_cause;

   assign por_s = src_if.synced[srst_pkg::SRC_POR];
   assign ext_s = src_if.synced[srst_pkg::SRC_EXT];
   assign bor_s = src_if.synced[srst_pkg::SRC_BOR];

   // power-on counts only before the supply has first come up
   // later detector pulses are noise until rstn
   assign por_ev = por_s & ~state_reg.powered;
   assign ext_ev = ext_s;
   assign bor_ev = bor_s & state_reg.brownout_reset_enable;
   // second time-out while the first is still pending
   assign wdt_ev = wdt_timeout & state_reg.first_to & state_reg.wdt_reset_enable;
   // whole-system request from the core control register
   assign sw_ev = reg_wr & (reg_addr == srst_pkg::OFS_CORE_IRQ_RST)
                  & reg_wdata[srst_pkg::SYS_REQ_BIT];
   // pulses start a sequence but cannot hold it
   assign any_ev = por_ev | ext_ev | bor_ev | wdt_ev | sw_ev;
   // level sources that keep the sequencer in hold
   assign level_busy = por_ev | ext_ev | bor_ev;
   assign wr_hit_cause = reg_wr & (reg_addr == srst_pkg::OFS_CAUSE);

   ////////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      state_next = state_reg;

      // register writes; identification registers have no write path
      if (reg_wr) begin
         if (reg_addr == srst_pkg::OFS_SUPPLY_CTRL) begin
            state_next.brownout_reset_enable = reg_wdata[srst_pkg::BOR_EN_BIT];
         end else if (reg_addr == srst_pkg::OFS_PERIPH_RST) begin
            state_next.peripheral_reset_regs = reg_wdata[NPERIPH-1:0];
         end else if (reg_addr == srst_pkg::OFS_PIN_ALT) begin
            state_next.alt_function_select = reg_wdata[srst_pkg::ALT_SEL_BIT];
         end else if (reg_addr == srst_pkg::OFS_WDT_CTRL) begin
            state_next.wdt_reset_enable = reg_wdata[srst_pkg::WDT_EN_BIT];
         end
      end

      // flags are kept until software writes the register or a power-on or pin reset clears them; hardware sets win below
      // a cause landing as software clears is kept
      if (wr_hit_cause) begin
         state_next.reset_cause_flags = reg_wdata[srst_pkg::CAUSE_W-1:0];
      end

      // watchdog first time-out tracking, a new time-out beats the clear
      // so a clear meeting a new time-out keeps it
      if (wdt_irq_clear) begin
         state_next.first_to = 1'b0;
      end
      if (wdt_timeout) begin
         state_next.first_to = 1'b1;
      end

      // a new reset event from any state
      // an event mid-sequence starts it again,
      // so a bouncing pin only lengthens reset
      if (any_ev) begin
         state_next.st = srst_pkg::ST_HOLD;
         state_next.cnt = '0;
         state_next.first_to = 1'b0;
         state_next.peripheral_reset_regs = '0;
         state_next.alt_function_select = 1'b0;
         if (por_ev) begin
            // power-on: only its own flag remains
            state_next.reset_cause_flags = srst_pkg::CAUSE_RESET;
            state_next.reset_cause_flags[srst_pkg::CAUSE_POR] = 1'b1;
            state_next.por_dom = 1'b1;
            state_next.pin_dom = 1'b1;
            state_next.brownout_reset_enable = 1'b0;
            state_next.wdt_reset_enable = 1'b0;
         end else if (ext_ev) begin
            // pin reset: only its own flag remains, tap left alone
            state_next.reset_cause_flags = srst_pkg::CAUSE_RESET;
            state_next.reset_cause_flags[srst_pkg::CAUSE_EXT] = 1'b1;
            state_next.pin_dom = 1'b1;
         end else begin
            // brown-out, watchdog and software add to the sticky flags
            state_next.reset_cause_flags = state_next.reset_cause_flags
               | (srst_pkg::CAUSE_W'(bor_ev) << srst_pkg::CAUSE_BOR)
               | (srst_pkg::CAUSE_W'(wdt_ev) << srst_pkg::CAUSE_WDT)
               | (srst_pkg::CAUSE_W'(sw_ev) << srst_pkg::CAUSE_SW);
         end
      end else begin
         case (state_reg.st)
            srst_pkg::ST_HOLD: begin
               // wait until every level source has gone inactive
               // a level still high re-enters via the event branch
               if (!level_busy) begin
                  state_next.st = srst_pkg::ST_STRETCH;
                  state_next.cnt = '0;
                  if (state_reg.por_dom) begin
                     state_next.powered = 1'b1;
                  end
               end
            end
            srst_pkg::ST_STRETCH: begin
               // release on a clock edge after a minimum hold
               // domain marks drop so tap and pin config release too
               if (state_reg.cnt == STRETCH_LAST) begin
                  state_next.st = srst_pkg::ST_FETCH_SP;
                  state_next.por_dom = 1'b0;
                  state_next.pin_dom = 1'b0;
               end else begin
                  state_next.cnt = state_reg.cnt + 1'b1;
               end
            end
            // boot: stack pointer, program counter, first instruction
            srst_pkg::ST_FETCH_SP: begin
               state_next.st = srst_pkg::ST_FETCH_PC;
            end
            srst_pkg::ST_FETCH_PC: begin
               state_next.st = srst_pkg::ST_FETCH_INSN;
            end
            srst_pkg::ST_FETCH_INSN: begin
               state_next.st = srst_pkg::ST_RUN;
            end
            default: begin
               state_next.st = srst_pkg::ST_RUN;
            end
         endcase
      end

      // read data for the cycle after the strobe only
      // zero otherwise, so stale words never look fresh
      state_next.rdata = '0;
      if (reg_rd) begin
         if (reg_addr == srst_pkg::OFS_IDENT0) begin
            state_next.rdata = IDENT0;
         end else if (reg_addr == srst_pkg::OFS_IDENT1) begin
            state_next.rdata = IDENT1;
         end else if (reg_addr == srst_pkg::OFS_CAPABILITY) begin
            state_next.rdata = CAPABILITY;
         end else if (reg_addr == srst_pkg::OFS_CAUSE) begin
            state_next.rdata[srst_pkg::CAUSE_W-1:0] = state_reg.reset_cause_flags;
         end else if (reg_addr == srst_pkg::OFS_SUPPLY_CTRL) begin
            state_next.rdata[srst_pkg::BOR_EN_BIT] = state_reg.brownout_reset_enable;
         end else if (reg_addr == srst_pkg::OFS_PERIPH_RST) begin
            state_next.rdata[NPERIPH-1:0] = state_reg.peripheral_reset_regs;
         end else if (reg_addr == srst_pkg::OFS_PIN_ALT) begin
            state_next.rdata[srst_pkg::ALT_SEL_BIT] = state_reg.alt_function_select;
         end else if (reg_addr == srst_pkg::OFS_WDT_CTRL) begin
            state_next.rdata[srst_pkg::WDT_EN_BIT] = state_reg.wdt_reset_enable;
         end else if (reg_addr == srst_pkg::OFS_STATUS) begin
            state_next.rdata[srst_pkg::ST_RUN_BIT] = (state_reg.st == srst_pkg::ST_RUN);
            state_next.rdata[srst_pkg::ST_POWERED_BIT] = state_reg.powered;
            state_next.rdata[srst_pkg::ST_FIRST_TO_BIT] = state_reg.first_to;
            // mode pins shown for diagnosis; nonzero is reserved
            state_next.rdata[srst_pkg::ST_TMODE0_BIT] = test_mode_pin0;
            state_next.rdata[srst_pkg::ST_TMODE1_BIT] = test_mode_pin1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register

   // controller power-up: hold with a power-on cause pending
   // flags start clear; the synchroniser's
   // first cycles bring the power-on bit
   always_ff @(posedge clock) begin
      if (!rstn) begin
         state_reg.st <= srst_pkg::ST_HOLD;
         state_reg.cnt <= '0;
         state_reg.reset_cause_flags <= srst_pkg::CAUSE_RESET;
         state_reg.powered <= 1'b0;
         state_reg.por_dom <= 1'b1;
         state_reg.pin_dom <= 1'b1;
         state_reg.first_to <= 1'b0;
         state_reg.brownout_reset_enable <= 1'b0;
         state_reg.wdt_reset_enable <= 1'b0;
         state_reg.peripheral_reset_regs <= '0;
         state_reg.alt_function_select <= 1'b0;
         state_reg.rdata <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // reset outputs

   logic async_sys;
   logic held;

   // raw sources pull the reset low at once, release waits for the sequencer
   // a raw pin glitch reaches the core reset,
   // so the board must keep the pin clean;
   // one too short to sync leaves no flag
   assign async_sys = (por_active & ~state_reg.powered) | ~ext_rst_n
                      | (brownout_detect & state_reg.brownout_reset_enable);
   assign held = (state_reg.st == srst_pkg::ST_HOLD) | (state_reg.st == srst_pkg::ST_STRETCH);

   // core domain: every source except a peripheral-only reset
   assign core_rst_n = ~async_sys & ~held;
   // test port state machine: power-on only
   // the pin spares it so a debugger stays attached
   assign dbg_tap_rst_n = ~(por_active & ~state_reg.powered) & ~state_reg.por_dom;
   // test port pin configuration: power-on or pin
   assign dbg_pin_cfg_rst_n = ~(por_active & ~state_reg.powered) & ext_rst_n
                              & ~state_reg.pin_dom;

   // one reset per peripheral covers all of its clocks
   // a select bit holds reset until cleared,
   // and any system reset clears the bits
   always_comb begin
      for (int i = 0; i < NPERIPH; i++) begin
         periph_rst_n[i] = core_rst_n & ~state_reg.peripheral_reset_regs[i];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // boot and status outputs

   // one pulse per boot step; the sequencer
   // never waits for the core side
   assign boot_fetch_sp = (state_reg.st == srst_pkg::ST_FETCH_SP);
   assign boot_fetch_pc = (state_reg.st == srst_pkg::ST_FETCH_PC);
   assign boot_fetch_insn = (state_reg.st == srst_pkg::ST_FETCH_INSN);
   assign core_run = (state_reg.st == srst_pkg::ST_RUN) & core_rst_n;
   assign nmi_select = state_reg.alt_function_select;
   assign reg_rdata = state_reg.rdata;
endmodule // srst_ctrl

// ===== testbench/srst_board.sv
// Purpose: board reset circuitry and supply monitor beside the controller
// Assumes: commands from the bench change just after a rising clock edge
// Notes: a press of any length keeps the pin low for at least MIN_PULSE cycles
module srst_board #(
   parameter int MIN_PULSE = 4
) (
   input wire logic clock,
   input wire logic press,
   input wire logic ramp,
   input wire logic sag,
   output logic por_active,
   output logic ext_rst_n,
   output logic brownout_detect,
   output logic test_mode_pin0,
   output logic test_mode_pin1
);
   timeunit 1ns;
   timeprecision 1ns;
   int hold_cnt = 0;

   initial begin
      por_active = 1'b0;
      ext_rst_n = 1'b1;
      brownout_detect = 1'b0;
   end

   // pin stays low for the whole minimum pulse after a press
   always @(posedge clock) begin
      if (press) begin
         hold_cnt <= MIN_PULSE;
      end else if (hold_cnt > 0) begin
         hold_cnt <= hold_cnt - 1;
      end
      ext_rst_n <= !(press || hold_cnt > 0);
      por_active <= ramp;
      brownout_detect <= sag;
   end

   // manufacturing test pins strapped to ground
   assign test_mode_pin0 = 1'b0;
   assign test_mode_pin1 = 1'b0;
endmodule // srst_board

// ===== testbench/srst_ctrl_chk.sv
// Purpose: concurrent checks on the ports of the reset controller
// Assumes: one clock domain, rstn synchronous active low
// Notes: attached by the bind at the foot of this file
module srst_ctrl_chk #(
   parameter int NPERIPH = 8,
   parameter logic [31:0] IDENT0 = 32'h0000_1234 // arbitrary value
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [srst_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [srst_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [srst_pkg::DATA_W-1:0] reg_rdata,
   input wire logic por_active,
   input wire logic ext_rst_n,
   input wire logic core_rst_n,
   input wire logic dbg_tap_rst_n,
   input wire logic dbg_pin_cfg_rst_n,
   input wire logic [NPERIPH-1:0] periph_rst_n,
   input wire logic boot_fetch_sp,
   input wire logic boot_fetch_pc,
   input wire logic boot_fetch_insn,
   input wire logic core_run,
   input wire logic nmi_select
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   // whole-system request written by software
   sequence sw_req_s;
      reg_wr && reg_addr == srst_pkg::OFS_CORE_IRQ_RST && reg_wdata[srst_pkg::SYS_REQ_BIT];
   endsequence
   // start-up fetches after release
   sequence boot_s;
      boot_fetch_sp ##1 boot_fetch_pc ##1 boot_fetch_insn ##1 core_run;
   endsequence

   boot_order_a: assert property ($rose(core_rst_n) |-> boot_s)
      else $error("start-up fetch order broken");
   sw_release_a: assert property (sw_req_s |=> !core_rst_n ##21 (core_rst_n && boot_fetch_sp))
      else $error("software reset length wrong");
   pin_resets_a: assert property (!ext_rst_n |-> !core_rst_n && !dbg_pin_cfg_rst_n)
      else $error("pin low without core reset");
   periph_with_core_a: assert property (!core_rst_n |-> periph_rst_n == '0)
      else $error("peripherals out of reset during core reset");
   tap_only_por_a: assert property ($fell(dbg_tap_rst_n) |-> por_active)
      else $error("test port reset without power-on");
   tap_whole_a: assert property (!dbg_tap_rst_n |-> !core_rst_n && !dbg_pin_cfg_rst_n)
      else $error("power-on reset incomplete");
   release_quiet_a: assert property ($rose(core_rst_n) |-> $past(ext_rst_n, 20)
      && !$past(por_active, 20))
      else $error("release while a source is active");
   nmi_gpio_a: assert property ($fell(core_rst_n) |-> ##[0:4] !nmi_select)
      else $error("nmi select kept over reset");
   ident_ro_a: assert property ($past(reg_rd) && $past(reg_addr) == srst_pkg::OFS_IDENT0
      |-> reg_rdata == IDENT0)
      else $error("identification word changed");
endmodule // srst_ctrl_chk

bind srst_ctrl srst_ctrl_chk #(.NPERIPH(NPERIPH), .IDENT0(IDENT0)) u_chk (.clock, .rstn,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .por_active, .ext_rst_n, .core_rst_n,
   .dbg_tap_rst_n, .dbg_pin_cfg_rst_n, .periph_rst_n, .boot_fetch_sp, .boot_fetch_pc,
   .boot_fetch_insn, .core_run, .nmi_select);

// ===== testbench/tb.sv
// Purpose: self-checking bench of the system reset controller
// Assumes: board model drives pin, power-on and brown-out levels
// Notes: first power-up, then register rows, then each further reset source by hand
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] ID0 = 32'h0000_1234; // arbitrary value
   localparam logic [31:0] ID1 = 32'h0000_5678; // arbitrary value
   localparam logic [31:0] CAP = 32'h0000_00FF; // arbitrary value
   typedef struct packed {
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] e;
   } srst_row_t;
   logic clock, rstn, reg_wr, reg_rd, wdt_timeout, wdt_irq_clear, press, ramp, sag;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic por_active, ext_rst_n, brownout_detect, test_mode_pin0, test_mode_pin1;
   logic core_rst_n, dbg_tap_rst_n, dbg_pin_cfg_rst_n, core_run, nmi_select;
   logic boot_fetch_sp, boot_fetch_pc, boot_fetch_insn;
   logic [7:0] periph_rst_n;
   srst_row_t rows [10];
   int err_total = 0;
   int n_tests = 0;

   srst_board #(.MIN_PULSE(4)) board (.clock, .press, .ramp, .sag, .por_active, .ext_rst_n,
      .brownout_detect, .test_mode_pin0, .test_mode_pin1);
   srst_ctrl #(.NPERIPH(8), .IDENT0(ID0), .IDENT1(ID1), .CAPABILITY(CAP)) DUT (.clock, .rstn,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .por_active, .ext_rst_n,
      .brownout_detect, .wdt_timeout, .wdt_irq_clear, .test_mode_pin0, .test_mode_pin1,
      .core_rst_n, .dbg_tap_rst_n, .dbg_pin_cfg_rst_n, .periph_rst_n, .boot_fetch_sp,
      .boot_fetch_pc, .boot_fetch_insn, .core_run, .nmi_select);

   // 50 ns system clock
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // report, compare and bus tasks
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      q = reg_rdata;
   endtask

   // one watchdog time-out, or one interrupt clear
   task automatic wdt(input logic clr);
      @(posedge clock);
      if (clr) wdt_irq_clear <= 1'b1;
      else wdt_timeout <= 1'b1;
      @(posedge clock);
      wdt_irq_clear <= 1'b0;
      wdt_timeout <= 1'b0;
   endtask

   // counts edges until the core runs, bounded
   task automatic wait_run(output int n);
      n = 0;
      while (core_run !== 1'b1 && n < 200) begin
         @(posedge clock);
         #1;
         n++;
      end
      if (n >= 200) begin
         err_total++;
         wrap_up();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      int n;
      logic [31:0] got;
      rows = '{'{8'h00, 32'hFFFF_FFFF, ID0}, '{8'h04, 32'hFFFF_FFFF, ID1},
         '{8'h08, 32'hFFFF_FFFF, CAP}, '{8'h24, 32'hFFFF_FFFF, 32'h0000_0003},
         '{8'h30, 32'hFFFF_FFFF, 32'h0000_0000}, '{8'h18, 32'h0000_0000, 32'h0000_0000},
         '{8'h10, 32'h0000_0002, 32'h0000_0002}, '{8'h20, 32'h0000_0001, 32'h0000_0001},
         '{8'h1C, 32'h0000_0001, 32'h0000_0001}, '{8'h0C, 32'h0000_0000, 32'h0000_0000}};
      {reg_wr, reg_rd, wdt_timeout, wdt_irq_clear, press, sag} = 6'h00;
      ramp = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      rstn = 1'b0;
      repeat (10) @(posedge clock);
      #1;
      chk(core_rst_n, 1'b0);
      chk(nmi_select, 1'b0);
      @(posedge clock);
      rstn <= 1'b1;
      // first power-up: detector high past rstn holds everything
      repeat (30) @(posedge clock);
      #1;
      chk({core_rst_n, dbg_tap_rst_n, dbg_pin_cfg_rst_n, periph_rst_n}, 32'h0);
      @(posedge clock);
      ramp <= 1'b0;
      wait_run(n);
      rd(8'h0C, got);
      chk(got, 32'h0000_0002);
      // register table, writes to read-only places ignored
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, got);
         chk(got, rows[i].e);
      end
      chk(nmi_select, 1'b1);
      // later detector pulse is ignored
      @(posedge clock);
      ramp <= 1'b1;
      repeat (6) @(posedge clock);
      ramp <= 1'b0;
      #1;
      chk({core_rst_n, dbg_tap_rst_n}, 2'h3);
      // a cleared first time-out does not reset
      wdt(1'b0);
      wdt(1'b1);
      wdt(1'b0);
      repeat (3) @(posedge clock);
      #1;
      chk(core_rst_n, 1'b1);
      wdt(1'b0);
      #1;
      chk({core_rst_n, dbg_tap_rst_n}, 2'h1);
      wait_run(n);
      chk(nmi_select, 1'b0);
      rd(8'h0C, got);
      chk(got, 32'h0000_0008);
      // whole-system request, exact length of the sequence
      wr(8'h18, 32'h0000_0004);
      #1;
      chk({core_rst_n, dbg_tap_rst_n}, 2'h1);
      wait_run(n);
      chk(n, 24);
      rd(8'h0C, got);
      chk(got, 32'h0000_0018);
      // peripheral reset by select bits only
      wr(8'h14, 32'h0000_0005);
      #1;
      chk({core_rst_n, periph_rst_n}, 9'h1FA);
      wr(8'h14, 32'h0000_0000);
      #1;
      chk(periph_rst_n, 8'hFF);
      // brown-out disabled, then enabled
      wr(8'h10, 32'h0000_0000);
      @(posedge clock);
      sag <= 1'b1;
      repeat (6) @(posedge clock);
      #1;
      chk(core_rst_n, 1'b1);
      wr(8'h10, 32'h0000_0002);
      repeat (4) @(posedge clock);
      #1;
      chk({core_rst_n, dbg_tap_rst_n}, 2'h1);
      @(posedge clock);
      sag <= 1'b0;
      wait_run(n);
      rd(8'h0C, got);
      chk(got, 32'h0000_001C);
      // short press on the reset pin
      @(posedge clock);
      press <= 1'b1;
      @(posedge clock);
      press <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      chk({core_rst_n, dbg_pin_cfg_rst_n, dbg_tap_rst_n}, 3'h1);
      wait_run(n);
      rd(8'h0C, got);
      chk(got, 32'h0000_0001);
      wrap_up();
   end
endmodule // tb
